// File: verilog/shift_port_pkg.sv
// Constants shared by the serial shift port and its data buffer.
// Assumes an 8-bit processor data space and a 200 MHz system clock.
package shift_port_pkg;
  localparam int          DATA_W        = 8;
  localparam int          CNT_W         = 4;
  localparam int          ADDR_W        = 8;
  localparam int          FIFO_DEPTH    = 16;
  localparam [7:0]        ADDR_SHIFT    = 8'hdd;
  localparam [7:0]        ADDR_DISARM   = 8'hc2;
  localparam [3:0]        CNT_RESET     = 4'h0;
  localparam [3:0]        CNT_LAST      = 4'h7;
  localparam int          CNT_TOP_BIT   = 3;
  localparam [7:0]        SHIFT_RESET   = 8'hff;
  localparam [7:0]        RDATA_IDLE    = 8'h00;
  localparam int          SYNC_STAGES   = 2;
endpackage

// File: verilog/shift_port.sv
// Serial shift port: 8-bit shift register, 4-bit counter, arm/disarm interrupt
// and a byte buffer. Assumes a processor write/read port on clk_in and a
// serial clock pin whose falling edges come from an outside master or from
// the port bit this block drives in master mode.
`timescale 1ns/100ps
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic             in_valid_in,
  output var  logic             in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output var  logic             out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign push         = in_valid_in && in_ready_out;
  assign pop          = out_valid_out && out_ready_in;
  assign out_data_out = mem[rptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // Storage
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wptr] <= in_data_in;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
      end
      count <= next_count;
    end
  end

  // Registered full and empty flags
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      in_ready_out  <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      in_ready_out  <= (next_count != (AW+1)'(DEPTH));
      out_valid_out <= (next_count != '0);
    end
  end

  a_fifo_no_overflow: assert property (@(posedge clk_in) disable iff (!rstn_in)
    count <= (AW+1)'(DEPTH))
    else $error("fifo fill level above depth");
  a_fifo_full_flag: assert property (@(posedge clk_in) disable iff (!rstn_in)
    in_ready_out == (count != (AW+1)'(DEPTH)))
    else $error("fifo ready disagrees with fill level");
endmodule

// How it works
// RQ1: Eight-bit shift register plus four-bit counter
// RQ2: Bits move most significant first
// RQ3: Serial clock falling edge advances both
// RQ4: After eight edges counter stops all shifting
// RQ5: Interrupt on eighth edge unless rewritten
// RQ6: Reset leaves interrupt disarmed
// RQ7: Shift write arms, disarm write disarms
// RQ8: Interrupt request is a falling level
// RQ9: Reset or shift write clears counter
// RQ10: Reception starts on next edges, no start
// RQ11: Slave mode: partner drives serial clock
// RQ12: Master mode: software drives clock pin
// RQ13: Data out open drain, data in input
// RQ14: Data lines may be tied together
// RQ15: Software may acknowledge and stretch clock
// RQ16: Separate port pin may be chip enable
// RQ17: Shift register at data address DDh
// RQ18: Disarm register written at C2h, value ignored
// RQ19: Shift left, data in to bit zero
module shift_port
  import shift_port_pkg::*;
#(
  parameter int DEPTH = shift_port_pkg::FIFO_DEPTH
) (
  input  wire logic                              clk_in,
  input  wire logic                              rstn_in,
  input  wire logic [shift_port_pkg::ADDR_W-1:0] cpu_addr_in,
  input  wire logic                              cpu_wr_in,
  input  wire logic                              cpu_rd_in,
  input  wire logic [shift_port_pkg::DATA_W-1:0] cpu_wdata_in,
  output logic      [shift_port_pkg::DATA_W-1:0] cpu_rdata_out,
  output logic                                   irq_n_out,
  input  wire logic                              scl_in,
  output logic                                   scl_out,
  output logic                                   scl_oe_out,
  input  wire logic                              sin_in,
  output logic                                   sin_out,
  output logic                                   sin_oe_out,
  output logic                                   sout_out,
  output logic                                   sout_oe_out,
  input  wire logic                              master_mode_in,
  input  wire logic                              soft_clk_in,
  input  wire logic                              stretch_in,
  input  wire logic                              ack_in,
  input  wire logic                              sout_en_in,
  output logic                                   rx_valid_out,
  input  wire logic                              rx_ready_in,
  output logic      [shift_port_pkg::DATA_W-1:0] rx_data_out
);
  import shift_port_pkg::*;

  logic [DATA_W-1:0] shift;
  logic [CNT_W-1:0]  cnt;
  logic              armed;
  logic              link_tgl;
  logic              link_bit;
  logic              tgl_s1;
  logic              tgl_s2;
  logic              tgl_s3;
  logic              edge_evt;
  logic              running;
  logic              step;
  logic              last_edge;
  logic              wr_shift;
  logic              wr_disarm;
  logic [DATA_W-1:0] next_shift;
  logic              pend;
  logic [DATA_W-1:0] byte_hold;
  logic              fifo_ready;
  logic              fifo_valid;
  logic [DATA_W-1:0] fifo_data;
  logic              fifo_take;

  // Link side: capture the data line on each serial clock falling edge
  always_ff @(negedge scl_in or negedge rstn_in) begin
    if (!rstn_in) begin
      link_bit <= 1'b1;
      link_tgl <= 1'b0;
    end else begin
      link_bit <= sin_in;    // [RQ3] [RQ10]
      link_tgl <= ~link_tgl; // [RQ3]
    end
  end

  // Edge event crosses into the system clock as a toggle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else begin
      tgl_s1 <= link_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  assign edge_evt   = tgl_s2 ^ tgl_s3;
  assign wr_shift   = cpu_wr_in && (cpu_addr_in == ADDR_SHIFT);    // [RQ17]
  assign wr_disarm  = cpu_wr_in && (cpu_addr_in == ADDR_DISARM);   // [RQ18]
  assign running    = !cnt[CNT_TOP_BIT] && !pend;                  // [RQ4]
  assign step       = edge_evt && running && !wr_shift;            // [RQ3]
  assign last_edge  = step && (cnt == CNT_LAST);
  assign next_shift = {shift[DATA_W-2:0], link_bit};               // [RQ2] [RQ19]
  assign fifo_take  = !rx_valid_out || rx_ready_in;

  // Shift register
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shift <= SHIFT_RESET;
    end else if (wr_shift) begin
      shift <= cpu_wdata_in;                                       // [RQ17]
    end else if (step) begin
      shift <= next_shift;                                         // [RQ1] [RQ19]
    end
  end

  // Bit counter
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt <= CNT_RESET;                                            // [RQ9]
    end else if (wr_shift) begin
      cnt <= CNT_RESET;                                            // [RQ9] [RQ10]
    end else if (step) begin
      cnt <= cnt + 1'b1;                                           // [RQ1] [RQ3]
    end
  end

  // Interrupt arming
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      armed <= 1'b0;                                               // [RQ6]
    end else if (wr_shift) begin
      armed <= 1'b1;                                               // [RQ7]
    end else if (wr_disarm) begin
      armed <= 1'b0;                                               // [RQ7]
    end
  end

  // Falling-edge interrupt request, held low until the next shift or disarm write
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_n_out <= 1'b1;
    end else if (last_edge && armed) begin
      irq_n_out <= 1'b0;                                           // [RQ5] [RQ8]
    end else if (wr_shift || wr_disarm) begin
      irq_n_out <= 1'b1;
    end
  end

  // Completed byte waits here until the buffer accepts it
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pend      <= 1'b0;
      byte_hold <= '0;
    end else if (last_edge) begin
      pend      <= 1'b1;
      byte_hold <= next_shift;
    end else if (pend && fifo_ready) begin
      pend      <= 1'b0;
    end
  end

  byte_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (pend),
    .in_ready_out  (fifo_ready),
    .in_data_in    (byte_hold),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_take),
    .out_data_out  (fifo_data)
  );

  // Buffer outputs, registered
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_valid_out <= 1'b0;
      rx_data_out  <= '0;
    end else if (fifo_take) begin
      rx_valid_out <= fifo_valid;
      rx_data_out  <= fifo_data;
    end
  end

  // Processor read of the shift register
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cpu_rdata_out <= RDATA_IDLE;
    end else if (cpu_rd_in && (cpu_addr_in == ADDR_SHIFT)) begin
      cpu_rdata_out <= shift;                                      // [RQ17]
    end else begin
      cpu_rdata_out <= RDATA_IDLE;
    end
  end

  // Pin drivers: open-drain data out, acknowledge and clock pins
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sout_out    <= 1'b0;
      sout_oe_out <= 1'b0;
      sin_out     <= 1'b0;
      sin_oe_out  <= 1'b0;
      scl_out     <= 1'b0;
      scl_oe_out  <= 1'b0;
    end else begin
      sout_out    <= 1'b0;
      sout_oe_out <= sout_en_in && !shift[DATA_W-1];               // [RQ13] [RQ14]
      sin_out     <= 1'b0;
      sin_oe_out  <= ack_in;                                       // [RQ15]
      scl_out     <= master_mode_in && soft_clk_in;                // [RQ12]
      scl_oe_out  <= master_mode_in || stretch_in;                 // [RQ12] [RQ15]
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  a_count_stops_eight: assert property (cnt <= 4'h8)                    // [RQ4]
    else $error("bit counter ran past eight");
  a_count_step_edge: assert property (step |=> cnt == $past(cnt) + 1'b1) // [RQ3]
    else $error("counter missed a serial clock edge");
  a_write_clears_cnt: assert property (wr_shift |=> cnt == CNT_RESET)   // [RQ9]
    else $error("shift write did not clear counter");
  a_shift_msb_first: assert property (step |=>                          // [RQ2]
    shift == {$past(shift[DATA_W-2:0]), $past(link_bit)})
    else $error("shift register did not move left");
  a_stopped_holds: assert property (                                    // [RQ4]
    cnt[CNT_TOP_BIT] && !wr_shift |=> $stable(cnt) && $stable(shift))
    else $error("shift continued after eight bits");
  a_irq_eighth_edge: assert property (last_edge && armed |=> !irq_n_out) // [RQ5]
    else $error("no interrupt on eighth edge");
  a_irq_needs_arm: assert property ($fell(irq_n_out) |-> $past(armed))  // [RQ7]
    else $error("interrupt while disarmed");
  a_disarm_write: assert property (wr_disarm && !wr_shift |=> !armed)   // [RQ7]
    else $error("disarm write left interrupt armed");
  a_irq_falls_once: assert property (                                   // [RQ8]
    !irq_n_out && !wr_shift && !wr_disarm |=> !irq_n_out)
    else $error("interrupt request rose without a write");
  a_sout_tracks_msb: assert property (                                  // [RQ13]
    ##1 sout_oe_out == ($past(sout_en_in) && !$past(shift[DATA_W-1])))
    else $error("data out does not show bit seven");
  a_master_drives_clk: assert property (master_mode_in |=> scl_oe_out)  // [RQ12]
    else $error("clock pin not driven in master mode");
  a_rx_holds_byte: assert property (                                    // [RQ10]
    rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_data_out))
    else $error("received byte dropped before it was taken");
  a_write_rearms_irq: assert property (                                 // [RQ7]
    (wr_shift || wr_disarm) && !(last_edge && armed) |=> irq_n_out)
    else $error("interrupt request still low after a write");
  a_write_arms: assert property (wr_shift |=> armed)                    // [RQ7]
    else $error("shift write did not arm the interrupt");
endmodule

`default_nettype wire

// File: testbench/serial_master_model.sv
// Outside serial master: clocks bytes MSB first on an open-drain data wire.
// Assumes the bench resolves both wires with pull-ups.
`timescale 1ns/100ps
`default_nettype none
module serial_master_model (
  output logic      scl_out,
  output logic      sda_out,
  input  wire logic sda_in
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // Eight falling edges at 48 ns; clock stands high outside frames
  task automatic send(input logic [7:0] b, output logic [7:0] got);
    #3.3;
    for (int i = 7; i >= 0; i--) begin
      #12 sda_out = b[i];
      #12 scl_out = 1'b0;
      got[i] = sda_in;
      #24 scl_out = 1'b1;
    end
    #12 sda_out = 1'b1;
  endtask
endmodule
`default_nettype wire

// File: testbench/shift_port_tb.sv
// Self-checking bench for the serial shift port and its byte buffer.
// Assumes the package and design are compiled first.
`timescale 1ns/100ps
`default_nettype none
module shift_port_tb;
  import shift_port_pkg::*;
  logic       clk_in = 1'b0, rstn_in = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rx_data, got;
  logic       wr = 1'b0, rd = 1'b0, irq_n, rx_valid, rx_ready = 1'b0;
  logic       scl_o, scl_oe, sin_o, sin_oe, sout_o, sout_oe, m_scl, m_sda;
  logic       mm = 1'b0, sclk = 1'b0, str = 1'b0, ack = 1'b0, sen = 1'b0;
  int         errors = 0, checks_done = 0;
  wire        scl_w = m_scl & ~(scl_oe & ~scl_o);
  wire        sin_w = m_sda & ~(sin_oe & ~sin_o) & ~(sout_oe & ~sout_o);

  always #2.5 clk_in = ~clk_in;

  serial_master_model m (.scl_out(m_scl), .sda_out(m_sda), .sda_in(sin_w));

  shift_port #(.DEPTH(16)) DUT (
    .clk_in(clk_in), .rstn_in(rstn_in), .cpu_addr_in(addr), .cpu_wr_in(wr),
    .cpu_rd_in(rd), .cpu_wdata_in(wdata), .cpu_rdata_out(rdata), .irq_n_out(irq_n),
    .scl_in(scl_w), .scl_out(scl_o), .scl_oe_out(scl_oe), .sin_in(sin_w),
    .sin_out(sin_o), .sin_oe_out(sin_oe), .sout_out(sout_o), .sout_oe_out(sout_oe),
    .master_mode_in(mm), .soft_clk_in(sclk), .stretch_in(str), .ack_in(ack),
    .sout_en_in(sen), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready),
    .rx_data_out(rx_data)
  );

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apply_reset;
    #1 rstn_in = 1'b0;
    repeat (12) @(posedge clk_in);
    #1 rstn_in = 1'b1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in) #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk_in) #1;
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in) #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk_in) #1;
    rd = 1'b0;
    chk("cpu_rdata_out", e, rdata);
  endtask

  // Shift and interrupt land a few cycles after the last falling edge
  task automatic irq_is(input logic e);
    repeat (8) @(posedge clk_in);
    #1 chk("irq_n_out", {7'h00, e}, {7'h00, irq_n});
  endtask

  task automatic t_reset;
    chk("irq_n_out", 8'h01, {7'h00, irq_n});
    chk("oe", 8'h00, {5'h00, scl_oe, sin_oe, sout_oe});
    rd_reg(ADDR_SHIFT, SHIFT_RESET);
    rd_reg(ADDR_DISARM, 8'h00);
    rd_reg(8'h10, 8'h00);
    m.send(8'h5a, got);
    irq_is(1'b1);
    rd_reg(ADDR_SHIFT, 8'h5a);
    $display("test reset done");
  endtask

  task automatic t_fifo;
    for (int i = 0; i < 18; i++) begin
      wr_reg(ADDR_SHIFT, 8'h00);
      m.send(8'h40 + i[7:0], got);
    end
    for (int i = 0; i < 17; i++) begin
      for (int k = 0; k < 40 && rx_valid !== 1'b1; k++) @(posedge clk_in) #1;
      chk("rx_valid_out", 8'h01, {7'h00, rx_valid});
      chk("rx_data_out", 8'h40 + i[7:0], rx_data);
      rx_ready = 1'b1;
      @(posedge clk_in) #1;
      rx_ready = 1'b0;
      @(posedge clk_in) #1;
    end
    $display("test fifo done");
  endtask

  task automatic t_irq;
    wr_reg(ADDR_SHIFT, 8'h00);
    m.send(8'h3c, got);
    irq_is(1'b0);
    rd_reg(ADDR_SHIFT, 8'h3c);
    m.send(8'hc3, got);
    irq_is(1'b0);
    rd_reg(ADDR_SHIFT, 8'h3c);
    wr_reg(ADDR_DISARM, 8'hff);
    chk("irq_n_out", 8'h01, {7'h00, irq_n});
    wr_reg(ADDR_SHIFT, 8'h00);
    wr_reg(ADDR_DISARM, 8'h00);
    m.send(8'h81, got);
    irq_is(1'b1);
    rd_reg(ADDR_SHIFT, 8'h81);
    $display("test irq done");
  endtask

  task automatic t_tx;
    sen = 1'b1;
    wr_reg(ADDR_SHIFT, 8'ha5);
    m.send(8'hff, got);
    chk("data wire", 8'ha5, got);
    rd_reg(ADDR_SHIFT, 8'ha5);
    sen = 1'b0;
    $display("test tx done");
  endtask

  task automatic t_pins;
    mm = 1'b1;
    repeat (2) @(posedge clk_in) #1;
    chk("scl wire", 8'h00, {7'h00, scl_w});
    sclk = 1'b1;
    repeat (2) @(posedge clk_in) #1;
    chk("scl wire", 8'h01, {7'h00, scl_w});
    mm = 1'b0;
    str = 1'b1;
    repeat (2) @(posedge clk_in) #1;
    chk("scl wire", 8'h00, {7'h00, scl_w});
    str = 1'b0;
    ack = 1'b1;
    repeat (2) @(posedge clk_in) #1;
    chk("sin wire", 8'h00, {7'h00, sin_w});
    ack = 1'b0;
    $display("test pins done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    apply_reset();
    t_reset();
    apply_reset();
    t_fifo();
    t_irq();
    t_tx();
    t_pins();
    report_and_stop();
  end

  initial begin
    #60000;
    errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
